// ===== rtl/disc_fmt_pkg.sv
// Shared constants for the drive end and the controller end of the disc link.
// What this block does
// - Drive emits index and sector pulses.
// - Four switches choose sectors per track.
// - Standard choices give fixed sector byte lengths.
// - Nonstandard counts add one short sector.
// - Any fault blocks the write gate.
// - Write protect switch refuses all writing.
// - Full format syncs header and data fields.
// - Read gate drops one byte before postamble end.
// - Short format rewrites header, 39 byte overhead.
// - Full format keeps header, 70 byte overhead.
// - Identification may carry protect or defect flags.
// - Read fails after 20 retries, ten per offset.
// - Write fails after three verified attempts.
// - Track holds 10,800 unformatted byte times.
package disc_fmt_pkg;
	localparam int CLK_HZ      = 200_000_000;
	localparam int BYTE_RATE   = 648_000;
	localparam int BYTE_CYC    = CLK_HZ / BYTE_RATE;
	localparam int TRACK_BYTES = 10800;
	localparam int SW_W        = 4;
	localparam int SEC_W       = 7;
	localparam int POS_W       = 14;

	localparam logic [POS_W-1:0] SEC_LEN_TAB [16] = '{
		14'h04B0, 14'h0438, 14'h0384, 14'h02D0, 14'h0258, 14'h021C, 14'h0168, 14'h012C,
		14'h010E, 14'h00C8, 14'h00B4, 14'h0606, 14'h03D5, 14'h033E, 14'h0303, 14'h027B
	};
	localparam logic [SEC_W-1:0] SEC_CNT_TAB [16] = '{
		7'h09, 7'h0A, 7'h0C, 7'h0F, 7'h12, 7'h14, 7'h1E, 7'h24,
		7'h28, 7'h36, 7'h3C, 7'h07, 7'h0B, 7'h0D, 7'h0E, 7'h11
	};

	localparam logic [7:0]       SYNC_BYTE  = 8'h01;
	localparam logic [POS_W-1:0] PRE_LEN    = 14'h000C;
	localparam logic [POS_W-1:0] POST_LEN   = 14'h0004;
	localparam logic [POS_W-1:0] OVH_SHORT  = 14'h0027;
	localparam logic [POS_W-1:0] OVH_FULL   = 14'h0046;
	localparam logic [4:0]       RD_RETRIES = 5'h14;
	localparam logic [4:0]       RD_PER_OFF = 5'h0A;
	localparam logic [4:0]       WR_TRIES   = 5'h03;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TGT  = 8'h04;
	localparam logic [7:0] A_ID   = 8'h08;
	localparam logic [7:0] A_PAT  = 8'h0C;
	localparam logic [7:0] A_DLEN = 8'h10;
	localparam logic [7:0] A_SLEN = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam logic [7:0] A_IST  = 8'h1C;
	localparam logic [7:0] A_IMSK = 8'h20;

	localparam int CTRL_GO   = 0;
	localparam int CTRL_WR   = 1;
	localparam int CTRL_FULL = 2;
	localparam int CTRL_FCLR = 3;
	localparam int IRQ_W     = 4;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_FAIL  = 1;
	localparam int IRQ_IDX   = 2;
	localparam int IRQ_REJ   = 3;

	localparam logic [POS_W-1:0] RST_DLEN = 14'h0400;
	localparam logic [POS_W-1:0] RST_SLEN = 14'h0438;
endpackage

// ===== rtl/disc_link.sv
// Link signals between the drive end and the controller end.
`timescale 1ns/100ps
interface disc_link;
	import disc_fmt_pkg::*;
	logic             byte_tick;
	logic             index;
	logic             sector;
	logic [SEC_W-1:0] sec_num;
	logic             wp;
	logic             fault;
	logic             unsafe;
	logic [7:0]       rdata;
	logic             wr_gate;
	logic             rd_gate;
	logic [7:0]       wdata;
	logic             offset;
	logic             fault_clr;

	modport drive (
		output byte_tick, index, sector, sec_num, wp, fault, unsafe, rdata,
		input  wr_gate, rd_gate, wdata, offset, fault_clr
	);
	modport ctrl (
		input  byte_tick, index, sector, sec_num, wp, fault, unsafe, rdata,
		output wr_gate, rd_gate, wdata, offset, fault_clr
	);
endinterface

// ===== rtl/tick_div.sv
// Divider giving a one-cycle enable pulse every DIV clocks.
`timescale 1ns/100ps
module tick_div #(
	parameter int DIV = 308
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	output logic      tick
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        tick_r;
	logic        tick_nxt;

	always_comb begin
		cnt_nxt  = cnt_r + 16'h0001;
		tick_nxt = 1'b0;
		if (cnt_r == 16'(DIV - 1)) begin
			cnt_nxt  = 16'h0000;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r  <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule

// ===== rtl/disc_drive.sv
// Drive end: byte timing, index and sector pulses, write inhibit and head data path.
`timescale 1ns/100ps
module disc_drive #(
	parameter int BYTE_DIV = disc_fmt_pkg::BYTE_CYC,
	parameter int TRACK    = disc_fmt_pkg::TRACK_BYTES
) (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic [disc_fmt_pkg::SW_W-1:0] sect_sw,
	input  wire logic                          wp_sw,
	input  wire logic                          fault_in,
	input  wire logic [7:0]                    head_rdata,
	output logic      [7:0]                    head_wdata,
	output logic                               head_we,
	output logic                               head_re,
	output logic                               offset_out,
	output logic                               wr_blocked,
	disc_link.drive                            link
);
	import disc_fmt_pkg::*;

	logic             tick;
	logic             run_r;
	logic             run_nxt;
	logic [SW_W-1:0]  sel_r;
	logic [SW_W-1:0]  sel_nxt;
	logic [POS_W-1:0] bpos_r;
	logic [POS_W-1:0] bpos_nxt;
	logic [POS_W-1:0] spos_r;
	logic [POS_W-1:0] spos_nxt;
	logic [SEC_W-1:0] snum_r;
	logic [SEC_W-1:0] snum_nxt;
	logic             idx_r;
	logic             idx_nxt;
	logic             sec_r;
	logic             sec_nxt;
	logic [POS_W-1:0] len;
	logic [SEC_W-1:0] cnt;
	logic             trk_end;
	logic             sec_end;

	logic             blk;
	logic             we_r;
	logic             we_nxt;
	logic             re_r;
	logic             re_nxt;
	logic [7:0]       wd_r;
	logic [7:0]       wd_nxt;
	logic [7:0]       rd_r;
	logic [7:0]       rd_nxt;
	logic             flt_r;
	logic             flt_nxt;
	logic             wp_r;
	logic             wp_nxt;
	logic             off_r;
	logic             off_nxt;
	logic             uns_r;
	logic             uns_nxt;

	// Byte time enable shared by all track timing.
	tick_div #(
		.DIV(BYTE_DIV)
	) u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (tick)
	);

	// Track and sector timing.
	always_comb begin
		len      = SEC_LEN_TAB[sel_r];
		cnt      = SEC_CNT_TAB[sel_r];
		trk_end  = (bpos_r == POS_W'(TRACK - 1));
		sec_end  = (spos_r == len - 14'h0001) && (snum_r != cnt);
		run_nxt  = run_r;
		sel_nxt  = sel_r;
		bpos_nxt = bpos_r;
		spos_nxt = spos_r;
		snum_nxt = snum_r;
		idx_nxt  = idx_r;
		sec_nxt  = sec_r;
		if (tick) begin
			idx_nxt = 1'b0;
			sec_nxt = 1'b0;
			if (!run_r || trk_end) begin
				run_nxt  = 1'b1;
				sel_nxt  = sect_sw;
				bpos_nxt = '0;
				spos_nxt = '0;
				snum_nxt = '0;
				idx_nxt  = 1'b1;
				sec_nxt  = 1'b1;
			end else begin
				bpos_nxt = bpos_r + 14'h0001;
				if (sec_end) begin
					spos_nxt = '0;
					snum_nxt = snum_r + 7'h01;
					sec_nxt  = 1'b1;
				end else begin
					spos_nxt = spos_r + 14'h0001;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_r  <= 1'b0;
			sel_r  <= '0;
			bpos_r <= '0;
			spos_r <= '0;
			snum_r <= '0;
			idx_r  <= 1'b0;
			sec_r  <= 1'b0;
		end else begin
			run_r  <= run_nxt;
			sel_r  <= sel_nxt;
			bpos_r <= bpos_nxt;
			spos_r <= spos_nxt;
			snum_r <= snum_nxt;
			idx_r  <= idx_nxt;
			sec_r  <= sec_nxt;
		end
	end

	// Head data path and write inhibit.
	always_comb begin
		blk     = link.wr_gate && (fault_in || wp_sw);
		we_nxt  = link.wr_gate && !fault_in && !wp_sw;
		re_nxt  = link.rd_gate && !we_nxt;
		wd_nxt  = we_nxt ? link.wdata : 8'h00;
		rd_nxt  = rd_r;
		if (tick && link.rd_gate) begin
			rd_nxt = head_rdata;
		end
		flt_nxt = fault_in;
		wp_nxt  = wp_sw;
		off_nxt = link.offset;
		uns_nxt = blk || (uns_r && !link.fault_clr);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			we_r  <= 1'b0;
			re_r  <= 1'b0;
			wd_r  <= 8'h00;
			rd_r  <= 8'h00;
			flt_r <= 1'b0;
			wp_r  <= 1'b0;
			off_r <= 1'b0;
			uns_r <= 1'b0;
		end else begin
			we_r  <= we_nxt;
			re_r  <= re_nxt;
			wd_r  <= wd_nxt;
			rd_r  <= rd_nxt;
			flt_r <= flt_nxt;
			wp_r  <= wp_nxt;
			off_r <= off_nxt;
			uns_r <= uns_nxt;
		end
	end

	// The live fault and protect levels also cut the registered gate at once.
	assign head_we        = we_r && !fault_in && !wp_sw;
	assign head_re        = re_r;
	assign head_wdata     = wd_r;
	assign offset_out     = off_r;
	assign wr_blocked     = uns_r;

	assign link.byte_tick = tick;
	assign link.index     = idx_r;
	assign link.sector    = sec_r;
	assign link.sec_num   = snum_r;
	assign link.wp        = wp_r;
	assign link.fault     = flt_r;
	assign link.unsafe    = uns_r;
	assign link.rdata     = rd_r;
endmodule

// ===== rtl/disc_ctrl.sv
// Controller end: AHB-Lite registers, record formatting, retries and interrupt.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module disc_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic             irq,
	disc_link.ctrl           link
);
	import disc_fmt_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN  = 2'b10,
		ST_EVAL = 2'b11
	} cst_t;

	logic             acc, apw_r, apw_nxt, go, fclr, busy, wr_pass, ev_done, ev_fail, ev_rej;
	logic [7:0]       apa_r, apa_nxt, id_r, id_nxt, pat_r, pat_nxt;
	logic [31:0]      hrd_r, hrd_nxt;
	logic             opw_r, opw_nxt, full_r, full_nxt;
	logic [SEC_W-1:0] tgt_r, tgt_nxt, snow_r, snow_nxt;
	logic [POS_W-1:0] dlen_r, dlen_nxt, slen_r, slen_nxt, ovh;
	logic [IRQ_W-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt, ev;
	cst_t             st_r, st_nxt;
	logic [POS_W-1:0] pos_r, pos_nxt, hend, eend, dbeg;
	logic             vfy_r, vfy_nxt, err_r, err_nxt, off_r, off_nxt;
	logic [4:0]       try_r, try_nxt;
	logic             wg_r, wg_nxt, rg_r, rg_nxt, c1_r, c1_nxt, c2_r, c2_nxt, idd_r;
	logic [7:0]       wd_r, wd_nxt, e1_r, e1_nxt, e2_r, e2_nxt, bv;
	logic             cv, in_w, in_r;

	// Bus slave and register file.
	always_comb begin
		acc      = hsel && hready && htrans[1];
		apw_nxt  = acc && hwrite;
		apa_nxt  = acc ? haddr[7:0] : apa_r;
		busy     = (st_r != ST_IDLE);
		hrd_nxt  = hrd_r;
		if (acc && !hwrite) begin
			case (haddr[7:0])
				A_CTRL:  hrd_nxt = {29'h0, full_r, opw_r, 1'b0};
				A_TGT:   hrd_nxt = {25'h0, tgt_r};
				A_ID:    hrd_nxt = {24'h0, id_r};
				A_PAT:   hrd_nxt = {24'h0, pat_r};
				A_DLEN:  hrd_nxt = {18'h0, dlen_r};
				A_SLEN:  hrd_nxt = {18'h0, slen_r};
				A_STAT:  hrd_nxt = {9'h0, snow_r, 3'h0, try_r, 6'h0, off_r, busy};
				A_IST:   hrd_nxt = {28'h0, ist_r};
				A_IMSK:  hrd_nxt = {28'h0, imsk_r};
				default: hrd_nxt = 32'h0000_0000;
			endcase
		end
		go       = apw_r && (apa_r == A_CTRL) && hwdata[CTRL_GO];
		fclr     = apw_r && (apa_r == A_CTRL) && hwdata[CTRL_FCLR];
		opw_nxt  = (apw_r && apa_r == A_CTRL && !busy) ? hwdata[CTRL_WR] : opw_r;
		full_nxt = (apw_r && apa_r == A_CTRL && !busy) ? hwdata[CTRL_FULL] : full_r;
		tgt_nxt  = (apw_r && apa_r == A_TGT) ? hwdata[SEC_W-1:0] : tgt_r;
		id_nxt   = (apw_r && apa_r == A_ID) ? hwdata[7:0] : id_r;
		pat_nxt  = (apw_r && apa_r == A_PAT) ? hwdata[7:0] : pat_r;
		dlen_nxt = (apw_r && apa_r == A_DLEN) ? hwdata[POS_W-1:0] : dlen_r;
		slen_nxt = (apw_r && apa_r == A_SLEN) ? hwdata[POS_W-1:0] : slen_r;
		imsk_nxt = (apw_r && apa_r == A_IMSK) ? hwdata[IRQ_W-1:0] : imsk_r;
		ev       = '0;
		ev[IRQ_DONE] = ev_done;
		ev[IRQ_FAIL] = ev_fail;
		ev[IRQ_IDX]  = link.index && !idd_r;
		ev[IRQ_REJ]  = ev_rej;
		ist_nxt  = ev | (ist_r & ~((apw_r && apa_r == A_IST) ? hwdata[IRQ_W-1:0] : 4'h0));
		snow_nxt = link.sector ? link.sec_num : snow_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			apw_r  <= 1'b0;
			apa_r  <= 8'h00;
			hrd_r  <= 32'h0000_0000;
			opw_r  <= 1'b0;
			full_r <= 1'b0;
			tgt_r  <= '0;
			id_r   <= 8'h00;
			pat_r  <= 8'h00;
			dlen_r <= RST_DLEN;
			slen_r <= RST_SLEN;
			imsk_r <= '0;
			ist_r  <= '0;
			snow_r <= '0;
			idd_r  <= 1'b0;
		end else begin
			apw_r  <= apw_nxt;
			apa_r  <= apa_nxt;
			hrd_r  <= hrd_nxt;
			opw_r  <= opw_nxt;
			full_r <= full_nxt;
			tgt_r  <= tgt_nxt;
			id_r   <= id_nxt;
			pat_r  <= pat_nxt;
			dlen_r <= dlen_nxt;
			slen_r <= slen_nxt;
			imsk_r <= imsk_nxt;
			ist_r  <= ist_nxt;
			snow_r <= snow_nxt;
			idd_r  <= link.index;
		end
	end

	// Record sequencer.
	always_comb begin
		wr_pass = opw_r && !vfy_r;
		ovh     = (go ? hwdata[CTRL_FULL] : full_r) ? OVH_FULL : OVH_SHORT;
		hend    = PRE_LEN + POST_LEN + 14'h0002;
		eend    = full_r ? hend + PRE_LEN + POST_LEN + dlen_r + 14'h0001 : hend + dlen_r;
		dbeg    = full_r ? hend + PRE_LEN : PRE_LEN + 14'h0001;
		bv      = 8'h00;
		cv      = 1'b0;
		if (pos_r == PRE_LEN) begin
			bv = SYNC_BYTE;
			cv = 1'b1;
		end else if (pos_r == PRE_LEN + 14'h0001) begin
			bv = id_r;
			cv = 1'b1;
		end else if (full_r && pos_r == dbeg) begin
			bv = SYNC_BYTE;
			cv = 1'b1;
		end else if (pos_r > dbeg && pos_r <= dbeg + dlen_r) begin
			bv = pat_r;
			cv = 1'b1;
		end
		in_w    = !full_r || pos_r >= hend;
		in_r    = full_r ? (pos_r < hend - 14'h0001 || (pos_r >= hend && pos_r < eend - 14'h0001))
		                 : (pos_r < eend - 14'h0001);
		st_nxt  = st_r;
		pos_nxt = pos_r;
		vfy_nxt = vfy_r;
		err_nxt = err_r;
		off_nxt = off_r;
		try_nxt = try_r;
		wg_nxt  = wg_r;
		rg_nxt  = rg_r;
		wd_nxt  = wd_r;
		e1_nxt  = e1_r;
		e2_nxt  = e2_r;
		c1_nxt  = c1_r;
		c2_nxt  = c2_r;
		ev_done = 1'b0;
		ev_fail = 1'b0;
		ev_rej  = 1'b0;
		case (st_r)
			ST_IDLE: begin
				if (go && ({1'b0, dlen_r} + {1'b0, ovh} > {1'b0, slen_r})) begin
					ev_rej = 1'b1;
				end else if (go) begin
					st_nxt  = ST_WAIT;
					vfy_nxt = 1'b0;
					err_nxt = 1'b0;
					off_nxt = 1'b0;
					try_nxt = 5'h00;
				end
			end
			ST_WAIT: begin
				if (link.byte_tick && link.sector && link.sec_num == tgt_r) begin
					st_nxt  = ST_RUN;
					pos_nxt = '0;
					err_nxt = 1'b0;
					c1_nxt  = 1'b0;
					c2_nxt  = 1'b0;
				end
			end
			ST_RUN: begin
				if (wr_pass && (link.fault || link.wp)) begin
					wg_nxt  = 1'b0;
					st_nxt  = ST_IDLE;
					ev_fail = 1'b1;
				end else if (link.byte_tick) begin
					wg_nxt  = wr_pass && in_w && pos_r != eend;
					rg_nxt  = !wr_pass && in_r && pos_r != eend;
					wd_nxt  = (wr_pass && in_w) ? bv : 8'h00;
					e1_nxt  = bv;
					c1_nxt  = !wr_pass && cv && in_r;
					e2_nxt  = e1_r;
					c2_nxt  = c1_r;
					err_nxt = err_r || (c2_r && link.rdata != e2_r);
					pos_nxt = pos_r + 14'h0001;
					if (pos_r == eend) begin
						st_nxt = ST_EVAL;
					end
				end
			end
			ST_EVAL: begin
				st_nxt  = ST_WAIT;
				err_nxt = 1'b0;
				if (wr_pass) begin
					vfy_nxt = 1'b1;
				end else if (!err_r) begin
					st_nxt  = ST_IDLE;
					ev_done = 1'b1;
				end else if (opw_r) begin
					vfy_nxt = 1'b0;
					try_nxt = try_r + 5'h01;
					if (try_r == WR_TRIES - 5'h01) begin
						st_nxt  = ST_IDLE;
						ev_fail = 1'b1;
					end
				end else if (try_r == RD_RETRIES) begin
					st_nxt  = ST_IDLE;
					ev_fail = 1'b1;
				end else begin
					try_nxt = try_r + 5'h01;
					off_nxt = off_r || (try_r == RD_PER_OFF);
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r  <= ST_IDLE;
			pos_r <= '0;
			vfy_r <= 1'b0;
			err_r <= 1'b0;
			off_r <= 1'b0;
			try_r <= 5'h00;
			wg_r  <= 1'b0;
			rg_r  <= 1'b0;
			wd_r  <= 8'h00;
			e1_r  <= 8'h00;
			e2_r  <= 8'h00;
			c1_r  <= 1'b0;
			c2_r  <= 1'b0;
		end else begin
			st_r  <= st_nxt;
			pos_r <= pos_nxt;
			vfy_r <= vfy_nxt;
			err_r <= err_nxt;
			off_r <= off_nxt;
			try_r <= try_nxt;
			wg_r  <= wg_nxt;
			rg_r  <= rg_nxt;
			wd_r  <= wd_nxt;
			e1_r  <= e1_nxt;
			e2_r  <= e2_nxt;
			c1_r  <= c1_nxt;
			c2_r  <= c2_nxt;
		end
	end

	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign hrdata         = hrd_r;
	assign irq            = |(ist_r & imsk_r);
	assign link.wr_gate   = wg_r;
	assign link.rd_gate   = rg_r;
	assign link.wdata     = wd_r;
	assign link.offset    = off_r;
	assign link.fault_clr = fclr;
endmodule

// ===== verification/disc_link_asserts.sv
// Checker of the disc link between the drive end and the controller end.
`timescale 1ns/100ps
module disc_link_asserts #(
	parameter int BYTE_DIV = 2,
	parameter int TRACK    = 1080
) (
	input wire logic                           hclk,
	input wire logic                           hresetn,
	input wire logic                           index,
	input wire logic                           sector,
	input wire logic [disc_fmt_pkg::SEC_W-1:0] sec_num,
	input wire logic                           wp,
	input wire logic                           fault,
	input wire logic                           unsafe,
	input wire logic                           wr_gate,
	input wire logic                           fault_clr
);
	logic [31:0] sw_r;
	logic [31:0] sw_nxt;
	logic [31:0] iw_r;
	logic [31:0] iw_nxt;
	logic [31:0] gap_r;
	logic [31:0] gap_nxt;
	logic        idx_r;
	logic        seen_r;

	always_comb begin
		sw_nxt = sector ? sw_r + 32'h1 : 32'h0;
		iw_nxt = index ? iw_r + 32'h1 : 32'h0;
		gap_nxt = (index && !idx_r) ? 32'h1 : gap_r + 32'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_r <= 32'h0;
			iw_r <= 32'h0;
			gap_r <= 32'h0;
			idx_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			sw_r <= sw_nxt;
			iw_r <= iw_nxt;
			gap_r <= gap_nxt;
			idx_r <= index;
			seen_r <= seen_r | (index && !idx_r);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_bad_write;
		wr_gate && (wp || fault);
	endsequence
	sequence s_gate_drop;
		##[1:3] !wr_gate;
	endsequence

	chk_index_sector: assert property ($rose(index) |-> sector ##1 (sec_num == '0))
		else $error("index pulse without sector zero");
	chk_sector_width: assert property ($fell(sector) |-> sw_r == BYTE_DIV)
		else $error("sector pulse not one byte time wide");
	chk_index_width: assert property ($fell(index) |-> iw_r == BYTE_DIV)
		else $error("index pulse not one byte time wide");
	chk_track_period: assert property (index && !idx_r && seen_r |-> gap_r == TRACK * BYTE_DIV)
		else $error("track length wrong");
	chk_secnum_step: assert property ($rose(sector) && !index |-> ##1 (sec_num == $past(sec_num, 2) + 7'h01))
		else $error("sector number did not step by one");
	chk_fault_drop: assert property (wr_gate && fault |-> s_gate_drop)
		else $error("write gate kept during fault");
	chk_wp_drop: assert property (wr_gate && wp |-> s_gate_drop)
		else $error("write gate kept while protected");
	chk_unsafe_set: assert property (s_bad_write |-> ##[1:3] unsafe)
		else $error("blocked write not flagged");
	chk_unsafe_hold: assert property (unsafe && !fault_clr |=> unsafe)
		else $error("unsafe flag dropped without clear");
	chk_unsafe_clear: assert property (fault_clr && !(wp || fault) |-> ##[1:3] !unsafe)
		else $error("unsafe flag not cleared");
endmodule

// ===== verification/testbench.sv
// Testbench joining the drive end and the controller end over the disc link.
`timescale 1ns/100ps
module testbench;
	import disc_fmt_pkg::*;
	localparam int DIV   = 2;
	localparam int TRK   = 1080;
	localparam int LIMIT = 95000;
	logic        hclk;
	logic        hresetn    = 1'b0;
	logic        hsel       = 1'b0;
	logic        hwrite     = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [31:0] hwdata     = 32'h0;
	logic [1:0]  htrans     = 2'b00;
	logic [2:0]  hsize      = 3'b010;
	logic [3:0]  sect_sw    = 4'hF;
	logic        wp_sw      = 1'b0;
	logic        fault_in   = 1'b0;
	logic        bad        = 1'b0;
	logic        sec_q      = 1'b0;
	logic        idx_q      = 1'b0;
	logic [15:0] rnd        = 16'h002B;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        head_we;
	logic        wr_blocked;
	logic [31:0] hrdata;
	logic [31:0] v;
	logic [7:0]  head_rdata;
	logic [7:0]  head_wdata;
	logic [7:0]  id;
	logic [7:0]  pat;
	logic [7:0]  mem [TRK];
	int          errors     = 0;
	int          checked    = 0;
	int          cyc        = 0;
	int          pos        = 0;
	int          sec_cnt    = 0;
	int          trk_cnt    = 0;
	int          idx_total  = 0;
	int          f;
	int          nz;
	int          pe;
	int          n0;

	assign hready = hreadyout;
	assign head_rdata = bad ? ~mem[pos] : mem[pos];

	disc_link u_disc_link ();
	disc_drive #(.BYTE_DIV(DIV), .TRACK(TRK)) u_disc_drive (
		.hclk(hclk), .hresetn(hresetn), .sect_sw(sect_sw), .wp_sw(wp_sw),
		.fault_in(fault_in), .head_rdata(head_rdata), .head_wdata(head_wdata),
		.head_we(head_we), .head_re(), .offset_out(), .wr_blocked(wr_blocked),
		.link(u_disc_link));
	disc_ctrl u_disc_ctrl (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
		.link(u_disc_link));
	disc_link_asserts #(.BYTE_DIV(DIV), .TRACK(TRK)) u_disc_link_asserts (
		.hclk(hclk), .hresetn(hresetn), .index(u_disc_link.index),
		.sector(u_disc_link.sector), .sec_num(u_disc_link.sec_num), .wp(u_disc_link.wp),
		.fault(u_disc_link.fault), .unsafe(u_disc_link.unsafe),
		.wr_gate(u_disc_link.wr_gate), .fault_clr(u_disc_link.fault_clr));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int exp_secs(input int code);
		int len;
		len = int'(SEC_LEN_TAB[code]);
		return (TRK + len - 1) / len;
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic run_op(input logic [31:0] ctl, input logic [1:0] hit,
			output logic [31:0] ist);
		bus(1'b1, A_IST, 32'h0000000F, ist);
		bus(1'b1, A_CTRL, ctl, ist);
		if (hit != 2'b00) begin
			wait (u_disc_link.wr_gate === 1'b1);
			@(posedge hclk);
			{fault_in, wp_sw} <= hit;
		end
		ist = 32'h0;
		while ((ist & 32'h0000000B) === 32'h0)
			bus(1'b0, A_IST, 32'h0, ist);
	endtask

	task automatic irq_chk(input logic e);
		@(negedge hclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge hclk);
	endtask

	// Medium: one byte per byte time, position restarts at index.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		sec_q <= u_disc_link.sector;
		idx_q <= u_disc_link.index;
		if (u_disc_link.index && !idx_q) begin
			trk_cnt <= sec_cnt;
			sec_cnt <= 1;
			idx_total <= idx_total + 1;
		end else if (u_disc_link.sector && !sec_q) begin
			sec_cnt <= sec_cnt + 1;
		end
		if (u_disc_link.byte_tick) begin
			pos <= u_disc_link.index ? 0 : (pos + 1) % TRK;
			if (head_we) begin
				mem[pos] <= head_wdata;
			end
		end
		if (cyc == LIMIT) begin
			errors = errors + 1;
			wrap_up();
		end
	end

	initial begin
		for (int i = 0; i < TRK; i++) mem[i] = 8'h00;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, A_DLEN, 32'h0, v);
		chk("dlen reset", {18'h0, RST_DLEN}, v);
		bus(1'b0, A_SLEN, 32'h0, v);
		chk("slen reset", {18'h0, RST_SLEN}, v);
		bus(1'b1, 8'h24, 32'hFFFFFFFF, v);
		bus(1'b0, 8'h24, 32'h0, v);
		chk("unmapped", 32'h0, v);
		sect_sw <= 4'h0;
		$display("test registers done");
		@(posedge u_disc_link.index);
		for (int c = 0; c < 16; c++) begin
			@(posedge hclk);
			sect_sw <= (c == 15) ? 4'hA : 4'(c + 1);
			@(posedge u_disc_link.index);
			repeat (2) @(posedge hclk);
			chk("sector count", exp_secs(c), trk_cnt);
		end
		$display("test sector codes done");
		bus(1'b1, A_IMSK, 32'h0, v);
		bus(1'b1, A_SLEN, 32'h000000B4, v);
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, A_DLEN, k ? 32'h0000006F : 32'h0000008E, v);
			run_op(k ? 32'h00000005 : 32'h00000001, 2'b00, v);
			chk("reject", 32'h00000008, v & 32'h0000000B);
		end
		irq_chk(1'b0);
		bus(1'b1, A_IMSK, 32'h00000008, v);
		irq_chk(1'b1);
		bus(1'b1, A_IST, 32'h0000000F, v);
		irq_chk(1'b0);
		$display("test overhead reject done");
		bus(1'b1, A_DLEN, 32'h00000010, v);
		bus(1'b1, A_IMSK, 32'h00000002, v);
		for (int m = 0; m < 2; m++) begin
			rnd = nxt(rnd);
			bus(1'b1, A_TGT, {30'h0, rnd[1:0]} + 32'h1, v);
			run_op(32'h00000003, m ? 2'b10 : 2'b01, v);
			chk("blocked write", 32'h00000002, v & 32'h0000000B);
			irq_chk(1'b1);
			chk("blocked flag", 32'h1, {31'h0, wr_blocked});
			wp_sw <= 1'b0;
			fault_in <= 1'b0;
			bus(1'b1, A_CTRL, 32'h00000008, v);
			bus(1'b1, A_IST, 32'h0000000F, v);
			irq_chk(1'b0);
			chk("blocked clear", 32'h0, {31'h0, wr_blocked});
		end
		$display("test write inhibit done");
		rnd = nxt(rnd);
		id = rnd[15:8] | 8'h80;
		pat = rnd[7:0] | 8'h01;
		bus(1'b1, A_TGT, {30'h0, rnd[1:0]} + 32'h1, v);
		bus(1'b1, A_ID, {24'h0, id}, v);
		bus(1'b1, A_PAT, {24'h0, pat}, v);
		bus(1'b1, A_DLEN, 32'h0000008D, v);
		run_op(32'h00000003, 2'b00, v);
		chk("write done", 32'h00000001, v & 32'h0000000B);
		f = -1;
		nz = 0;
		pe = 0;
		for (int i = TRK - 1; i >= 0; i--) begin
			if (mem[i] !== 8'h00) begin
				f = i;
				nz++;
			end
		end
		for (int i = 0; i < 141; i++) begin
			if (mem[f + 2 + i] !== pat) pe++;
		end
		chk("sync byte", {24'h0, SYNC_BYTE}, {24'h0, mem[f]});
		chk("id byte", {24'h0, id}, {24'h0, mem[f + 1]});
		chk("pattern errors", 32'h0, pe);
		chk("written bytes", 32'h0000008F, nz);
		run_op(32'h00000001, 2'b00, v);
		chk("read done", 32'h00000001, v & 32'h0000000B);
		bus(1'b1, A_DLEN, 32'h00000040, v);
		for (int k = 0; k < 2; k++) begin
			run_op(k ? 32'h00000005 : 32'h00000007, 2'b00, v);
			chk("full format", 32'h00000001, v & 32'h0000000B);
		end
		$display("test write and read done");
		bad <= 1'b1;
		rnd = nxt(rnd);
		bus(1'b1, A_DLEN, {27'h0, rnd[4:0]} + 32'h1, v);
		n0 = idx_total;
		run_op(32'h00000003, 2'b00, v);
		chk("verify fail", 32'h00000002, v & 32'h0000000B);
		chk("attempt span", 32'h1, {31'h0, (idx_total - n0 >= 5) && (idx_total - n0 <= 8)});
		bad <= 1'b0;
		$display("test write retries done");
		wrap_up();
	end
endmodule
